// ==== ccc_pkg.sv ====
// Purpose: Constants and types for the capacitance converter control block.
// Assumes: 125 MHz system clock, byte-wide register port from a serial front end.
// Notes: Conversion times are kept in ms; cycle counts are derived here.
// Function
// - Range bits 7:6 pick full scale per channel.
// - Setup bit 5 selects differential versus single-ended.
// - Config bit 4 enables channel 1.
// - Config bit 3 enables channel 2.
// - Mode bits 2:0 decode idle, continuous, single, etc.
// - Mode 101 runs offset calibration on enabled channels.
// - Configuration register resets to all zeros.
// - Positive DAC bit 7 connects positive offset DAC.
// - Positive DAC bits 4:0 hold level, reset zero.
// - Negative DAC bit 7 connects negative offset DAC.
// - Negative DAC bits 4:0 hold level, reset zero.
// - Filter bits 5:4 set conversion time.
// - Modulator bit stream feeds third-order filter.
// - Filter output scaled by calibration before reading.
// - Modulator input muxed to the converting channel.
// - Excitation routed to pin of converting channel.
// - Square-wave excitation for whole conversion.
// - Setup registers at 0x0B and 0x0E, reset zero.
// - Ready bit low when unread data available.
// - Data update skipped during a data read.
`default_nettype none

package ccc_pkg;
    localparam int CLK_HZ = 125_000_000;
    localparam int MS_PER_S = 1000;
    localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
    localparam int CONV0_MS = 5;
    localparam int CONV1_MS = 20;
    localparam int CONV2_MS = 50;
    localparam int CONV3_MS = 60;
    localparam int CONV0_CYC = CONV0_MS * CYC_PER_MS;
    localparam int CONV1_CYC = CONV1_MS * CYC_PER_MS;
    localparam int CONV2_CYC = CONV2_MS * CYC_PER_MS;
    localparam int CONV3_CYC = CONV3_MS * CYC_PER_MS;
    localparam int CNT_W = 23;
    localparam int EXC_W = 16;
    localparam int EXC_HALF_DEF = 63;
    localparam int DEC_W = 5;

    // Register addresses.
    localparam logic [7:0] A_STATUS = 8'h00;
    localparam logic [7:0] A_DATA1_H = 8'h01;
    localparam logic [7:0] A_DATA1_L = 8'h02;
    localparam logic [7:0] A_DATA2_H = 8'h03;
    localparam logic [7:0] A_DATA2_L = 8'h04;
    localparam logic [7:0] A_OFF1_H = 8'h05;
    localparam logic [7:0] A_OFF1_L = 8'h06;
    localparam logic [7:0] A_OFF2_H = 8'h07;
    localparam logic [7:0] A_OFF2_L = 8'h08;
    localparam logic [7:0] A_SETUP1 = 8'h0B;
    localparam logic [7:0] A_SETUP2 = 8'h0E;
    localparam logic [7:0] A_CFG = 8'h0F;
    localparam logic [7:0] A_POS_OFFSET_DAC_LEVEL = 8'h11;
    localparam logic [7:0] A_NEG_OFFSET_DAC_LEVEL = 8'h12;
    localparam logic [7:0] A_CFG2 = 8'h1A;

    // Field positions, write masks and reset values.
    localparam int RANGE_HI = 7;
    localparam int RANGE_LO = 6;
    localparam int DIFF_BIT = 5;
    localparam int EN1_BIT = 4;
    localparam int EN2_BIT = 3;
    localparam int DAC_CON_BIT = 7;
    localparam int DAC_LVL_HI = 4;
    localparam int RATE_HI = 5;
    localparam int RATE_LO = 4;
    localparam int ST_PDOWN_BIT = 7;
    localparam int ST_LAST_BIT = 2;
    localparam logic [7:0] SETUP_WMASK = 8'hE0;
    localparam logic [7:0] CFG_WMASK = 8'h1F;
    localparam logic [7:0] DAC_WMASK = 8'h9F;
    localparam logic [7:0] CFG2_WMASK = 8'h30;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [15:0] OFF_RST = 16'h8000;
    localparam logic [15:0] DATA_RST = 16'h0000;
    localparam logic [15:0] RES_MASK = 16'hFFF0;
    localparam logic [15:0] CODE_MAX = 16'hFFFF;

    // Operating mode codes.
    localparam logic [2:0] MODE_IDLE = 3'h0;
    localparam logic [2:0] MODE_CONT = 3'h1;
    localparam logic [2:0] MODE_SINGLE = 3'h2;
    localparam logic [2:0] MODE_PDOWN = 3'h3;
    localparam logic [2:0] MODE_OFFCAL = 3'h5;
    localparam logic [2:0] MODE_GAINCAL = 3'h6;

    typedef enum logic [0:0] {SEQ_IDLE, SEQ_CONV} ccc_seq_t;

    // Analog front end controls.
    typedef struct packed {
        logic exc_a;
        logic exc_b;
        logic mod_sel;
        logic [1:0] range;
        logic diff;
        logic pos_offset_dac_level_con;
        logic [4:0] pos_offset_dac_level_lvl;
        logic neg_offset_dac_level_con;
        logic [4:0] neg_offset_dac_level_lvl;
        logic converting;
        logic pdown;
    } ccc_afe_t;

    // Register port request.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ccc_req_t;

    typedef struct packed {
        ccc_seq_t seq;
        logic [1:0] sync;
        logic [1:0][7:0] setup;
        logic [7:0] cfg;
        logic [7:0] pos_offset_dac_level;
        logic [7:0] neg_offset_dac_level;
        logic [7:0] cfg2;
        logic [1:0][15:0] data;
        logic [1:0][15:0] offs;
        logic [1:0] rdy_n;
        logic last_ch;
        logic ch;
        logic [CNT_W-1:0] cnt;
        logic [EXC_W-1:0] exc_cnt;
        logic exc_ph;
        logic [15:0] i1;
        logic [15:0] i2;
        logic [15:0] i3;
        logic [15:0] d1;
        logic [15:0] d2;
        logic [15:0] d3;
        logic [DEC_W-1:0] dec;
        logic [15:0] code;
        logic [7:0] rdata;
        ccc_afe_t afe;
    } ccc_state_t;
endpackage

`default_nettype wire

// ==== ccc_ctrl.sv ====
// Purpose: Configuration, conversion sequencing, filter and result registers.
// Assumes: A serial front end on clk_sys_in presents byte register accesses.
// Notes: Analog parts sit outside; this block drives their controls.
`default_nettype none

module ccc_ctrl #(
    parameter int CONV0_CYC = ccc_pkg::CONV0_CYC,
    parameter int CONV1_CYC = ccc_pkg::CONV1_CYC,
    parameter int CONV2_CYC = ccc_pkg::CONV2_CYC,
    parameter int CONV3_CYC = ccc_pkg::CONV3_CYC,
    parameter int EXC_HALF = ccc_pkg::EXC_HALF_DEF
) (
    // Clock and reset.
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    // Register port from the serial front end.
    input wire ccc_pkg::ccc_req_t req_in,
    input wire logic [1:0] rd_busy_in,
    output logic [7:0] reg_rdata_out,
    // Modulator bit stream pin.
    input wire logic mod_bit_in,
    // Front end controls and ready flags.
    output ccc_pkg::ccc_afe_t afe_out,
    output logic [1:0] ready_n_out
);
    ccc_pkg::ccc_state_t s_r;
    ccc_pkg::ccc_state_t s_nxt;
    logic [2:0] mode;
    logic [1:0] en;
    logic active;
    logic done;
    logic cal;
    logic [ccc_pkg::CNT_W-1:0] conv_len;
    localparam int EXC_W = ccc_pkg::EXC_W;
    // Last count of an excitation half period.
    localparam logic [EXC_W-1:0] EXC_W_HALF = EXC_W'(EXC_HALF - 1);

    // Subtract the offset coefficient around midscale and keep 12 bits.
    function automatic logic [15:0] scale(input logic [15:0] code,
                                          input logic [15:0] off);
        logic signed [17:0] v;
        v = $signed({2'b00, code}) - $signed({2'b00, off})
            + $signed({2'b00, ccc_pkg::OFF_RST});
        if (v < 0) begin
            scale = ccc_pkg::DATA_RST;
        end else if (v > $signed({2'b00, ccc_pkg::CODE_MAX})) begin
            scale = ccc_pkg::RES_MASK;
        end else begin
            scale = v[15:0] & ccc_pkg::RES_MASK;
        end
    endfunction

    // Mode and channel enables decoded from the configuration register.
    assign mode = s_r.cfg[2:0];
    assign en = {s_r.cfg[ccc_pkg::EN2_BIT], s_r.cfg[ccc_pkg::EN1_BIT]};
    assign cal = (mode == ccc_pkg::MODE_OFFCAL) || (mode == ccc_pkg::MODE_GAINCAL);
    assign active = (en != 2'b00) && ((mode == ccc_pkg::MODE_CONT) || cal
                    || (mode == ccc_pkg::MODE_SINGLE));
    assign done = (s_r.seq == ccc_pkg::SEQ_CONV) && active
                  && (s_r.cnt == conv_len - 1'b1);

    // Conversion length from the filter rate field.
    always_comb begin
        case (s_r.cfg2[ccc_pkg::RATE_HI:ccc_pkg::RATE_LO])
            2'b00: conv_len = ccc_pkg::CNT_W'(CONV0_CYC);
            2'b01: conv_len = ccc_pkg::CNT_W'(CONV1_CYC);
            2'b10: conv_len = ccc_pkg::CNT_W'(CONV2_CYC);
            default: conv_len = ccc_pkg::CNT_W'(CONV3_CYC);
        endcase
    end

    // Next state of the whole block.
    always_comb begin
        logic [15:0] x;
        logic [15:0] c1;
        logic [15:0] c2;
        logic [15:0] c3;
        logic restart;
        logic [1:0] landed;
        s_nxt = s_r;
        x = 16'h0000;
        c1 = 16'h0000;
        c2 = 16'h0000;
        c3 = 16'h0000;
        restart = 1'b0;
        landed = 2'b00;
        // Two-stage synchroniser; only the second stage feeds the filter.
        s_nxt.sync = {s_r.sync[0], mod_bit_in};

        case (s_r.seq)
            ccc_pkg::SEQ_IDLE: begin
                if (active) begin
                    s_nxt.ch = !en[0];
                    restart = 1'b1;
                end
            end
            ccc_pkg::SEQ_CONV: begin
                if (!active) begin
                    // Mode changed by the host; abandon the conversion.
                    s_nxt.seq = ccc_pkg::SEQ_IDLE;
                end else begin
                    s_nxt.cnt = s_r.cnt + 1'b1;
                    // Square wave on the measured capacitor all through.
                    if (s_r.exc_cnt == EXC_W_HALF) begin
                        s_nxt.exc_cnt = '0;
                        s_nxt.exc_ph = !s_r.exc_ph;
                    end else begin
                        s_nxt.exc_cnt = s_r.exc_cnt + 1'b1;
                    end
                    // One modulator sample per excitation period.
                    if (s_r.exc_cnt == EXC_W_HALF && s_r.exc_ph) begin
                        x = {15'h0000, s_r.sync[1]};
                        s_nxt.i1 = s_r.i1 + x;
                        s_nxt.i2 = s_r.i2 + s_nxt.i1;
                        s_nxt.i3 = s_r.i3 + s_nxt.i2;
                        s_nxt.dec = s_r.dec + 1'b1;
                        if (&s_r.dec) begin
                            c1 = s_nxt.i3 - s_r.d1;
                            c2 = c1 - s_r.d2;
                            c3 = c2 - s_r.d3;
                            s_nxt.d1 = s_nxt.i3;
                            s_nxt.d2 = c1;
                            s_nxt.d3 = c2;
                            s_nxt.code = c3[15] ? ccc_pkg::CODE_MAX : {c3[14:0], 1'b0};
                        end
                    end
                    if (done) begin
                        if (mode == ccc_pkg::MODE_OFFCAL) begin
                            s_nxt.offs[s_r.ch] = s_r.code;
                        end else if (!cal && !rd_busy_in[s_r.ch]) begin
                            s_nxt.data[s_r.ch] = scale(s_r.code, s_r.offs[s_r.ch]);
                            s_nxt.rdy_n[s_r.ch] = 1'b0;
                            landed[s_r.ch] = 1'b1;
                            s_nxt.last_ch = s_r.ch;
                        end
                        if (!s_r.ch && en[1]) begin
                            s_nxt.ch = 1'b1;
                            restart = 1'b1;
                        end else begin
                            s_nxt.seq = ccc_pkg::SEQ_IDLE;
                            if (mode != ccc_pkg::MODE_CONT) begin
                                s_nxt.cfg[2:0] = ccc_pkg::MODE_IDLE;
                            end
                        end
                    end
                end
            end
            default: s_nxt.seq = ccc_pkg::SEQ_IDLE;
        endcase

        // A fresh conversion clears the counters and the filter.
        if (restart) begin
            s_nxt.seq = ccc_pkg::SEQ_CONV;
            s_nxt.cnt = '0;
            s_nxt.exc_cnt = '0;
            s_nxt.exc_ph = 1'b0;
            s_nxt.i1 = 16'h0000;
            s_nxt.i2 = 16'h0000;
            s_nxt.i3 = 16'h0000;
            s_nxt.d1 = 16'h0000;
            s_nxt.d2 = 16'h0000;
            s_nxt.d3 = 16'h0000;
            s_nxt.dec = '0;
        end

        // Host writes follow the sequencer so a host write wins the mode field.
        if (req_in.wr) begin
            case (req_in.addr)
                ccc_pkg::A_SETUP1: s_nxt.setup[0] = req_in.wdata & ccc_pkg::SETUP_WMASK;
                ccc_pkg::A_SETUP2: s_nxt.setup[1] = req_in.wdata & ccc_pkg::SETUP_WMASK;
                ccc_pkg::A_CFG: s_nxt.cfg = req_in.wdata & ccc_pkg::CFG_WMASK;
                ccc_pkg::A_POS_OFFSET_DAC_LEVEL: s_nxt.pos_offset_dac_level = req_in.wdata & ccc_pkg::DAC_WMASK;
                ccc_pkg::A_NEG_OFFSET_DAC_LEVEL: s_nxt.neg_offset_dac_level = req_in.wdata & ccc_pkg::DAC_WMASK;
                ccc_pkg::A_CFG2: s_nxt.cfg2 = req_in.wdata & ccc_pkg::CFG2_WMASK;
                ccc_pkg::A_OFF1_H: s_nxt.offs[0][15:8] = req_in.wdata;
                ccc_pkg::A_OFF1_L: s_nxt.offs[0][7:0] = req_in.wdata;
                ccc_pkg::A_OFF2_H: s_nxt.offs[1][15:8] = req_in.wdata;
                ccc_pkg::A_OFF2_L: s_nxt.offs[1][7:0] = req_in.wdata;
                default: s_nxt.cfg = s_nxt.cfg;
            endcase
        end

        // Reads; the low data byte ends a pair and marks the data as read.
        if (req_in.rd) begin
            case (req_in.addr)
                ccc_pkg::A_STATUS: begin
                    s_nxt.rdata = 8'h00;
                    s_nxt.rdata[ccc_pkg::ST_PDOWN_BIT] = (mode == ccc_pkg::MODE_PDOWN);
                    s_nxt.rdata[ccc_pkg::ST_LAST_BIT] = s_r.last_ch;
                    s_nxt.rdata[1:0] = s_r.rdy_n;
                end
                ccc_pkg::A_DATA1_H: s_nxt.rdata = s_r.data[0][15:8];
                ccc_pkg::A_DATA1_L: s_nxt.rdata = s_r.data[0][7:0];
                ccc_pkg::A_DATA2_H: s_nxt.rdata = s_r.data[1][15:8];
                ccc_pkg::A_DATA2_L: s_nxt.rdata = s_r.data[1][7:0];
                ccc_pkg::A_OFF1_H: s_nxt.rdata = s_r.offs[0][15:8];
                ccc_pkg::A_OFF1_L: s_nxt.rdata = s_r.offs[0][7:0];
                ccc_pkg::A_OFF2_H: s_nxt.rdata = s_r.offs[1][15:8];
                ccc_pkg::A_OFF2_L: s_nxt.rdata = s_r.offs[1][7:0];
                ccc_pkg::A_SETUP1: s_nxt.rdata = s_r.setup[0];
                ccc_pkg::A_SETUP2: s_nxt.rdata = s_r.setup[1];
                ccc_pkg::A_CFG: s_nxt.rdata = s_r.cfg;
                ccc_pkg::A_POS_OFFSET_DAC_LEVEL: s_nxt.rdata = s_r.pos_offset_dac_level;
                ccc_pkg::A_NEG_OFFSET_DAC_LEVEL: s_nxt.rdata = s_r.neg_offset_dac_level;
                ccc_pkg::A_CFG2: s_nxt.rdata = s_r.cfg2;
                default: s_nxt.rdata = 8'h00;
            endcase
            // Set wins: a result landing now keeps its ready flag low, even when the
            // flag was already low, so the fresh result is never marked as read.
            if (req_in.addr == ccc_pkg::A_DATA1_L && !landed[0]) begin
                s_nxt.rdy_n[0] = 1'b1;
            end
            if (req_in.addr == ccc_pkg::A_DATA2_L && !landed[1]) begin
                s_nxt.rdy_n[1] = 1'b1;
            end
        end

        // Front end controls follow the channel that converts.
        s_nxt.afe.converting = (s_nxt.seq == ccc_pkg::SEQ_CONV);
        s_nxt.afe.mod_sel = s_nxt.ch;
        s_nxt.afe.exc_a = s_nxt.afe.converting && !s_nxt.ch && s_nxt.exc_ph;
        s_nxt.afe.exc_b = s_nxt.afe.converting && s_nxt.ch && s_nxt.exc_ph;
        s_nxt.afe.range = s_nxt.setup[s_nxt.ch][ccc_pkg::RANGE_HI:ccc_pkg::RANGE_LO];
        s_nxt.afe.diff = s_nxt.setup[s_nxt.ch][ccc_pkg::DIFF_BIT];
        s_nxt.afe.pos_offset_dac_level_con = s_nxt.pos_offset_dac_level[ccc_pkg::DAC_CON_BIT];
        s_nxt.afe.pos_offset_dac_level_lvl = s_nxt.pos_offset_dac_level[ccc_pkg::DAC_LVL_HI:0];
        s_nxt.afe.neg_offset_dac_level_con = s_nxt.neg_offset_dac_level[ccc_pkg::DAC_CON_BIT];
        s_nxt.afe.neg_offset_dac_level_lvl = s_nxt.neg_offset_dac_level[ccc_pkg::DAC_LVL_HI:0];
        s_nxt.afe.pdown = (s_nxt.cfg[2:0] == ccc_pkg::MODE_PDOWN);
    end

    // State register; reset leaves every register at its documented value.
    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            s_r <= '0;
            s_r.setup <= {ccc_pkg::REG_RST, ccc_pkg::REG_RST};
            s_r.cfg <= ccc_pkg::REG_RST;
            s_r.pos_offset_dac_level <= ccc_pkg::REG_RST;
            s_r.neg_offset_dac_level <= ccc_pkg::REG_RST;
            s_r.offs <= {ccc_pkg::OFF_RST, ccc_pkg::OFF_RST};
            s_r.rdy_n <= 2'b11;
            s_r.seq <= ccc_pkg::SEQ_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign reg_rdata_out = s_r.rdata;
    assign afe_out = s_r.afe;
    assign ready_n_out = s_r.rdy_n;

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);

    sequence s_finish_ch1;
        done && !s_r.ch;
    endsequence

    property p_rst_cfg;
        $past(nrst_in) == 1'b0 |-> s_r.cfg == ccc_pkg::REG_RST && !afe_out.converting;
    endproperty
    a_rst_cfg: assert property (p_rst_cfg) else $error("Config not zero after reset.");

    property p_exc_route;
        afe_out.exc_a |-> !afe_out.exc_b && !afe_out.mod_sel;
    endproperty
    a_exc_route: assert property (p_exc_route) else $error("Excitation on wrong pin.");

    property p_exc_idle;
        !afe_out.converting |-> !afe_out.exc_a && !afe_out.exc_b;
    endproperty
    a_exc_idle: assert property (p_exc_idle) else $error("Excitation outside conversion.");

    property p_mux;
        afe_out.diff == s_r.setup[afe_out.mod_sel][ccc_pkg::DIFF_BIT]
        && afe_out.range == s_r.setup[afe_out.mod_sel][ccc_pkg::RANGE_HI:ccc_pkg::RANGE_LO];
    endproperty
    a_mux: assert property (p_mux) else $error("Front end not set for channel.");

    property p_rdy;
        s_finish_ch1 ##0 (!cal && !rd_busy_in[0]) |=> !ready_n_out[0];
    endproperty
    a_rdy: assert property (p_rdy) else $error("Ready not low after result.");

    property p_busy_skip;
        s_finish_ch1 ##0 rd_busy_in[0] |=> $stable(s_r.data[0]);
    endproperty
    a_busy_skip: assert property (p_busy_skip) else $error("Data changed during read.");

    property p_single_idle;
        done && mode == ccc_pkg::MODE_SINGLE && (s_r.ch || !en[1]) && !req_in.wr
        |=> s_r.cfg[2:0] == ccc_pkg::MODE_IDLE ##1 !afe_out.converting;
    endproperty
    a_single_idle: assert property (p_single_idle) else $error("Single run not idle.");

    property p_order;
        s_finish_ch1 ##0 en[1] |=> afe_out.mod_sel && afe_out.converting;
    endproperty
    a_order: assert property (p_order) else $error("Second channel not next.");

    property p_offcal;
        s_r.seq == ccc_pkg::SEQ_IDLE && mode == ccc_pkg::MODE_OFFCAL && en != 2'b00
        |=> afe_out.converting;
    endproperty
    a_offcal: assert property (p_offcal) else $error("Offset calibration not started.");

    // Second-channel results follow the same ready and read-skip rules.
    sequence s_finish_ch2;
        done && s_r.ch;
    endsequence

    property p_second_channel_ready_n;
        s_finish_ch2 ##0 (!cal && !rd_busy_in[1]) |=> !ready_n_out[1];
    endproperty
    a_second_channel_ready_n: assert property (p_second_channel_ready_n) else $error("Ready 2 not low after result.");

    property p_busy_skip2;
        s_finish_ch2 ##0 rd_busy_in[1] |=> $stable(s_r.data[1]);
    endproperty
    a_busy_skip2: assert property (p_busy_skip2) else $error("Data 2 not held.");

    // Reading the low data byte marks it read when nothing lands at once.
    property p_rd_clr;
        req_in.rd && req_in.addr == ccc_pkg::A_DATA1_L && !done |=> ready_n_out[0];
    endproperty
    a_rd_clr: assert property (p_rd_clr) else $error("Ready not cleared by read.");

    // Calibration runs leave the result registers alone.
    property p_cal_data;
        done && cal |=> $stable(s_r.data);
    endproperty
    a_cal_data: assert property (p_cal_data) else $error("Calibration wrote data.");

    // A continuous run idles one cycle, then starts again at channel 1.
    sequence s_finish_last;
        done && (s_r.ch || !en[1]);
    endsequence

    property p_cont_loop;
        s_finish_last ##0 (mode == ccc_pkg::MODE_CONT && en[0] && !req_in.wr)
        |=> !afe_out.converting ##1 afe_out.converting && !afe_out.mod_sel;
    endproperty
    a_cont_loop: assert property (p_cont_loop) else $error("No continuous restart.");
endmodule // ccc_ctrl

`default_nettype wire

// ==== ccc_mod_model.sv ====
// Purpose: Behavioural modulator that answers the converter with a one-bit stream.
// Assumes: The bench sets the ones-density; the stream is sampled on the system clock.
// Notes: Outside a conversion the line toggles so a stale value never looks valid.
`default_nettype none

module ccc_mod_model (
    // Clock.
    input wire logic clk_sys_in,
    // Front end state and wanted density.
    input wire logic sampling_in,
    input wire logic [3:0] density_in,
    // Bit stream to the converter.
    output logic mod_bit_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] acc_r = 4'h0;
    logic [4:0] sum;

    // First-order accumulator: the carry gives a ones-density of density_in/16.
    assign sum = {1'b0, acc_r} + {1'b0, density_in};
    always @(posedge clk_sys_in) begin
        acc_r <= sum[3:0];
        mod_bit_out <= sampling_in ? sum[4] : (mod_bit_out !== 1'b1);
    end
endmodule // ccc_mod_model

`default_nettype wire

// ==== test_cap_converter_config_control.sv ====
// Purpose: Self-checking bench for the converter control block.
// Assumes: Short conversion counts of 400/800/1200/1600 cycles and EXC_HALF of 4.
// Notes: Every register write keeps reserved bits at zero.
`default_nettype none

module test_cap_converter_config_control;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int CONV [4] = '{400, 800, 1200, 1600};
    logic clk_sys_in = 1'b0;
    logic nrst_in = 1'b0;
    ccc_pkg::ccc_req_t req = '0;
    logic [1:0] rd_busy = 2'b00;
    logic [3:0] dens = 4'h5;
    logic [7:0] rdata;
    logic mod_bit;
    ccc_pkg::ccc_afe_t afe;
    logic [1:0] rdy_n;
    int failures = 0;
    int cmp_count = 0;
    int n0, n1, good, bad;
    logic [7:0] v, d;
    logic [2:0] s0, s1;

    // Free-running 125 MHz clock.
    always #4 clk_sys_in = ~clk_sys_in;

    ccc_ctrl #(.CONV0_CYC(400), .CONV1_CYC(800), .CONV2_CYC(1200), .CONV3_CYC(1600),
        .EXC_HALF(4)) dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .req_in(req),
        .rd_busy_in(rd_busy), .reg_rdata_out(rdata), .mod_bit_in(mod_bit),
        .afe_out(afe), .ready_n_out(rdy_n));

    ccc_mod_model model (.clk_sys_in(clk_sys_in), .sampling_in(afe.converting),
        .density_in(dens), .mod_bit_out(mod_bit));

    task automatic end_sim;
        if (failures == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One write strobe, then an idle cycle so the strobe is never re-raised in one step.
    task automatic wr(input logic [7:0] a, input logic [7:0] dv);
        @(posedge clk_sys_in);
        req <= '{1'b1, 1'b0, a, dv};
        @(posedge clk_sys_in);
        req <= '0;
    endtask

    // Read data is registered, so it is taken one full cycle after the strobe edge.
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(posedge clk_sys_in);
        req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk_sys_in);
        req <= '0;
        @(posedge clk_sys_in);
        #1 q = rdata;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        rd(a, v);
        chk({24'h0, v}, {24'h0, e});
    endtask

    // Starts an operation and profiles it: cycles per channel, exciter pin activity.
    task automatic conv(input logic [7:0] c);
        int k;
        logic pa, pb;
        n0 = 0; n1 = 0; good = 0; bad = 0; k = 0;
        wr(ccc_pkg::A_CFG, c);
        while (afe.converting !== 1'b1 && k < 20) begin
            @(posedge clk_sys_in);
            #1 k++;
        end
        pa = afe.exc_a;
        pb = afe.exc_b;
        while (afe.converting === 1'b1 && k < 8000) begin
            if (afe.mod_sel) begin
                n1++; s1 = {afe.range, afe.diff};
                good += (afe.exc_b !== pb); bad += afe.exc_a;
            end else begin
                n0++; s0 = {afe.range, afe.diff};
                good += (afe.exc_a !== pa); bad += afe.exc_b;
            end
            pa = afe.exc_a;
            pb = afe.exc_b;
            @(posedge clk_sys_in);
            #1 k++;
        end
    endtask

    // Hang guard, well beyond the roughly 7400 cycles the sequence needs.
    initial begin
        #480000;
        failures++;
        end_sim();
    end

    // Main sequence.
    initial begin
        repeat (12) @(posedge clk_sys_in);
        nrst_in <= 1'b1;
        @(posedge clk_sys_in);
        #1 chk(afe, 0);
        chk(rdy_n, 2'b11);
        rchk(ccc_pkg::A_CFG, 8'h00);
        rchk(ccc_pkg::A_SETUP1, 8'h00);
        rchk(ccc_pkg::A_SETUP2, 8'h00);
        rchk(ccc_pkg::A_POS_OFFSET_DAC_LEVEL, 8'h00);
        rchk(ccc_pkg::A_NEG_OFFSET_DAC_LEVEL, 8'h00);
        rchk(ccc_pkg::A_CFG2, 8'h00);
        rchk(ccc_pkg::A_STATUS, 8'h03);
        rchk(8'h1B, 8'h00);
        wr(ccc_pkg::A_SETUP1, 8'hE0);
        wr(ccc_pkg::A_SETUP2, 8'h40);
        wr(ccc_pkg::A_POS_OFFSET_DAC_LEVEL, 8'h9F);
        wr(ccc_pkg::A_NEG_OFFSET_DAC_LEVEL, 8'h85);
        rchk(ccc_pkg::A_SETUP1, 8'hE0);
        rchk(ccc_pkg::A_NEG_OFFSET_DAC_LEVEL, 8'h85);
        chk({afe.pos_offset_dac_level_con, afe.pos_offset_dac_level_lvl}, 6'h3F);
        chk({afe.neg_offset_dac_level_con, afe.neg_offset_dac_level_lvl}, 6'h25);
        wr(ccc_pkg::A_POS_OFFSET_DAC_LEVEL, 8'h0A);
        rchk(ccc_pkg::A_POS_OFFSET_DAC_LEVEL, 8'h0A);
        chk({afe.pos_offset_dac_level_con, afe.pos_offset_dac_level_lvl}, 6'h0A);
        // Every filter rate on channel 1 alone, then read the result to clear ready.
        for (int r = 0; r < 4; r++) begin
            wr(ccc_pkg::A_CFG2, 8'(r << 4));
            conv(8'h12);
            chk(n0, CONV[r]);
            chk(n1, 0);
            chk(good > 0, 1);
            chk(bad, 0);
            rchk(ccc_pkg::A_CFG, 8'h10);
            chk(rdy_n, 2'b10);
            rd(ccc_pkg::A_DATA1_L, v);
            chk(v[3:0], 4'h0);
            chk(rdy_n, 2'b11);
        end
        wr(ccc_pkg::A_CFG2, 8'h00);
        // Both channels, single: channel order, routing and per-channel setup.
        conv(8'h1A);
        chk(n0, 400);
        chk(n1, 400);
        chk(bad, 0);
        chk(s0, 3'b111);
        chk(s1, 3'b010);
        rchk(ccc_pkg::A_STATUS, 8'h04);
        rchk(ccc_pkg::A_CFG, 8'h18);
        rd(ccc_pkg::A_DATA1_H, d);
        rd(ccc_pkg::A_DATA1_L, v);
        rd(ccc_pkg::A_DATA2_L, v);
        chk(v[3:0], 4'h0);
        // A result that lands during a data read is dropped; the density change
        // makes a stored result visibly different.
        @(posedge clk_sys_in);
        rd_busy <= 2'b11;
        dens <= 4'hC;
        conv(8'h1A);
        chk(rdy_n, 2'b11);
        @(posedge clk_sys_in);
        rd_busy <= 2'b00;
        rchk(ccc_pkg::A_DATA1_H, d);
        conv(8'h15);
        chk(n0, 400);
        rchk(ccc_pkg::A_CFG, 8'h10);
        conv(8'h16);
        chk(n0, 400);
        rchk(ccc_pkg::A_CFG, 8'h10);
        wr(ccc_pkg::A_CFG, 8'h13);
        rd(ccc_pkg::A_STATUS, v);
        chk({v[7], afe.pdown, afe.converting}, 3'b110);
        wr(ccc_pkg::A_CFG, 8'h14);
        repeat (5) @(posedge clk_sys_in);
        #1 chk({afe.pdown, afe.converting}, 2'b00);
        // Continuous mode restarts at channel 1 and stops on a mode change.
        conv(8'h19);
        chk(n0, 400);
        chk(n1, 400);
        repeat (3) @(posedge clk_sys_in);
        #1 chk({afe.converting, afe.mod_sel}, 2'b10);
        rchk(ccc_pkg::A_CFG, 8'h19);
        wr(ccc_pkg::A_CFG, 8'h18);
        repeat (3) @(posedge clk_sys_in);
        #1 chk(afe.converting, 1'b0);
        end_sim();
    end
endmodule // test_cap_converter_config_control

`default_nettype wire
